// ### slcd_defines.svh
// Register map, field positions, reset values and timing counts of the segment LCD controller
`ifndef SLCD_DEFINES_SVH
`define SLCD_DEFINES_SVH

`define SLCD_RAM_BASE      16'h7000
`define SLCD_RAM_LAST      16'h703c
`define SLCD_AREA1_OFFSET  16'h0020
`define SLCD_REG_CLK       16'h7100
`define SLCD_REG_CTL       16'h7104
`define SLCD_REG_TIM1      16'h7108
`define SLCD_REG_TIM2      16'h710c
`define SLCD_REG_PWR       16'h7110
`define SLCD_REG_DSP       16'h7114
`define SLCD_REG_INTF      16'h7118
`define SLCD_REG_INTE      16'h711c

`define SLCD_CLK_WMASK     16'h0173
`define SLCD_CTL_WMASK     16'h0003
`define SLCD_TIM1_WMASK    16'h0f03
`define SLCD_TIM2_WMASK    16'h0303
`define SLCD_PWR_WMASK     16'hff17
`define SLCD_DSP_WMASK     16'h0077
`define SLCD_INT_WMASK     16'h0001

`define SLCD_CLK_RESET     16'h0100
`define SLCD_CTL_RESET     16'h0000
`define SLCD_TIM1_RESET    16'h0703
`define SLCD_TIM2_RESET    16'h0100
`define SLCD_PWR_RESET     16'h8000
`define SLCD_DSP_RESET     16'h0070
`define SLCD_INT_RESET     16'h0000

`define SLCD_CLK_DEBUG_CLOCK_RUN     8
`define SLCD_CLK_DIV       6:4
`define SLCD_CLK_SRC       1:0
`define SLCD_CTL_DIS       1
`define SLCD_CTL_EN        0
`define SLCD_TIM1_FRM      11:8
`define SLCD_TIM1_DUTY     1:0
`define SLCD_TIM2_BST      9:8
`define SLCD_TIM2_INVERSE_LINE_COUNT    1:0
`define SLCD_PWR_EXVC      15
`define SLCD_PWR_BSTEN     4
`define SLCD_PWR_REGULATOR_ENABLE      0
`define SLCD_DSP_SEGMENT_ORDER_SELECT    6
`define SLCD_DSP_COMMON_ORDER_SELECT    5
`define SLCD_DSP_DSPREV    4
`define SLCD_DSP_AREA      2
`define SLCD_DSP_CTRL      1:0
`define SLCD_INT_FRAME     0

`define SLCD_LINE_UNIT     8'h08

`endif

// ### slcd_pkg.sv
// Types shared by the segment LCD controller
package slcd_pkg;

    typedef enum logic [1:0] {
        SLCD_DSP_OFF    = 2'h0,
        SLCD_DSP_NORMAL = 2'h1,
        SLCD_DSP_ALLON  = 2'h2,
        SLCD_DSP_ALLOFF = 2'h3
    } slcd_display_control_t;

    typedef enum logic [1:0] {
        SLCD_ST_IDLE = 2'b01,
        SLCD_ST_RUN  = 2'b10
    } slcd_state_t;

    typedef struct packed {
        logic [31:0] seg;
        logic [3:0]  com;
        logic        oe_n;
    } slcd_pins_t;

endpackage

// ### slcd_ctrl.sv
// APB segment LCD controller: display RAM, control registers, frame sequencer
`timescale 1ns/10ps
`include "slcd_defines.svh"

module slcd_ctrl
    import slcd_pkg::*;
#(
    parameter int NSEG = 32
) (
    input  wire logic        pclk,         // 100 MHz bus clock
    input  wire logic        presetn,      // Async reset, active low
    input  wire logic        psel,         // APB select
    input  wire logic        penable,      // APB enable
    input  wire logic        pwrite,       // APB direction
    input  wire logic [15:0] paddr,        // APB byte address
    input  wire logic [31:0] pwdata,       // APB write data
    input  wire logic [3:0]  pstrb,        // APB byte strobes
    output logic      [31:0] prdata,       // APB read data
    output logic             pready,       // APB ready
    output logic             pslverr,      // APB error on unmapped address
    input  wire logic        debug_mode,   // Processor in debug, asynchronous
    output slcd_pins_t       lcd_pins,     // Segment and common pins
    output logic             frame_irq,    // Frame interrupt request
    output logic             booster_clk,  // Booster pump clock
    output logic             regulator_en  // Voltage regulator on
);

    if (NSEG < 1 || NSEG > 32) begin : g_bad_nseg
        $error("NSEG must lie in 1..32");
    end

    function automatic logic [3:0] div_shift(input logic [1:0] src, input logic [2:0] div);
        // Slow sources start at divide by four, the external input at one
        div_shift = (src == 2'h2 || src == 2'h3) ? {1'b0, div} : 4'({1'b0, div} + 4'h2);
    endfunction

    function automatic logic [5:0] bst_half(input logic [1:0] code);
        unique case (code)
            2'h0: bst_half = 6'h02;
            2'h1: bst_half = 6'h08;
            2'h2: bst_half = 6'h10;
            2'h3: bst_half = 6'h20;
        endcase
    endfunction

    // Word compare; byte offset bits are don't-care, so any lane hits its word
    function automatic logic word_hit(input logic [15:0] addr, input logic [15:0] base);
        word_hit = (addr[15:2] == base[15:2]);
    endfunction

    // Registers
    logic [7:0]  ram [0:63];
    logic [15:0] clk_reg, ctl_reg, tim1_reg, tim2_reg, pwr_reg, dsp_reg, inte_reg;
    logic [15:0] clk_next, ctl_next, tim1_next, tim2_next, pwr_next, dsp_next, inte_next;
    logic        flag_reg, flag_next;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    logic        dbg_meta_reg, dbg_sync_reg;
    slcd_state_t state_reg, state_next;
    logic [8:0]  pre_cnt_reg;
    logic [7:0]  ltim_reg;
    logic [1:0]  line_reg;
    logic [1:0]  inv_cnt_reg;
    logic        pol_reg;
    logic [5:0]  bst_cnt_reg;
    logic        bst_reg;
    slcd_pins_t  pins_reg, pins_next;

    // Bus decode
    wire setup_ph = psel && !penable;
    wire wr_acc   = psel && penable && pwrite;
    wire hit_ram  = (paddr >= `SLCD_RAM_BASE) && (paddr <= (`SLCD_RAM_LAST + 16'h0003));
    wire hit_clk  = word_hit(paddr, `SLCD_REG_CLK);
    wire hit_ctl  = word_hit(paddr, `SLCD_REG_CTL);
    wire hit_tim1 = word_hit(paddr, `SLCD_REG_TIM1);
    wire hit_tim2 = word_hit(paddr, `SLCD_REG_TIM2);
    wire hit_pwr  = word_hit(paddr, `SLCD_REG_PWR);
    wire hit_dsp  = word_hit(paddr, `SLCD_REG_DSP);
    wire hit_intf = word_hit(paddr, `SLCD_REG_INTF);
    wire hit_inte = word_hit(paddr, `SLCD_REG_INTE);
    wire hit_any  = hit_ram | hit_clk | hit_ctl | hit_tim1 | hit_tim2 | hit_pwr | hit_dsp | hit_intf | hit_inte;
    wire [3:0] ram_word = paddr[5:2];

    // Field views
    wire        module_enable    = ctl_reg[`SLCD_CTL_EN];
    wire        dis_en   = ctl_reg[`SLCD_CTL_DIS];
    wire [1:0]  duty     = tim1_reg[`SLCD_TIM1_DUTY];
    wire [3:0]  frm      = tim1_reg[`SLCD_TIM1_FRM];
    wire [1:0]  inverse_line_count    = tim2_reg[`SLCD_TIM2_INVERSE_LINE_COUNT];
    slcd_display_control_t display_control;
    assign display_control = slcd_display_control_t'(dsp_reg[`SLCD_DSP_CTRL]);
    wire        area_sel = dsp_reg[`SLCD_DSP_AREA];
    wire        segment_order_select   = dsp_reg[`SLCD_DSP_SEGMENT_ORDER_SELECT];
    wire        common_order_select   = dsp_reg[`SLCD_DSP_COMMON_ORDER_SELECT];
    wire        dsprev   = dsp_reg[`SLCD_DSP_DSPREV];

    // Register write decode
    wire wr_clk  = wr_acc && hit_clk && !module_enable;
    wire wr_ctl  = wr_acc && hit_ctl;
    wire shutdown = wr_ctl && module_enable && !pwdata[`SLCD_CTL_EN] && (display_control != SLCD_DSP_OFF);
    wire [15:0] wmask_pwr = pwdata[15:0] & `SLCD_PWR_WMASK;

    assign clk_next  = wr_clk ? (pwdata[15:0] & `SLCD_CLK_WMASK) : clk_reg;
    assign ctl_next  = wr_ctl ? (pwdata[15:0] & `SLCD_CTL_WMASK) : ctl_reg;
    assign tim1_next = (wr_acc && hit_tim1) ? (pwdata[15:0] & `SLCD_TIM1_WMASK) : tim1_reg;
    assign tim2_next = (wr_acc && hit_tim2) ? (pwdata[15:0] & `SLCD_TIM2_WMASK) : tim2_reg;
    assign inte_next = (wr_acc && hit_inte) ? (pwdata[15:0] & `SLCD_INT_WMASK) : inte_reg;

    // Selecting external voltage also drops the regulator
    always_comb begin
        pwr_next = pwr_reg;
        if (wr_acc && hit_pwr) begin
            pwr_next = wmask_pwr;
            if (wmask_pwr[`SLCD_PWR_EXVC]) begin
                pwr_next[`SLCD_PWR_REGULATOR_ENABLE] = 1'b0;
            end
        end
        if (shutdown) begin
            pwr_next[`SLCD_PWR_REGULATOR_ENABLE] = 1'b0;
        end
    end

    always_comb begin
        dsp_next = dsp_reg;
        if (wr_acc && hit_dsp) begin
            dsp_next = pwdata[15:0] & `SLCD_DSP_WMASK;
        end
        if (shutdown) begin
            dsp_next[`SLCD_DSP_CTRL] = SLCD_DSP_OFF;
        end
    end

    // Operating clock: synchronised debug level, source and divider
    wire       clk_run  = module_enable && (!dbg_sync_reg || clk_reg[`SLCD_CLK_DEBUG_CLOCK_RUN]);
    wire [3:0] pre_shift = div_shift(clk_reg[`SLCD_CLK_SRC], clk_reg[`SLCD_CLK_DIV]);
    wire [9:0] pre_span  = 10'((10'h001 << pre_shift) - 10'h001);
    wire       tick      = (state_reg == SLCD_ST_RUN) && clk_run && (pre_cnt_reg == pre_span[8:0]);

    // Frame sequencing
    wire [7:0] line_last = 8'((({4'h0, frm} + 8'h01) * `SLCD_LINE_UNIT) - 8'h01);
    wire       line_end  = tick && (ltim_reg == line_last);
    wire       frame_evt = line_end && (line_reg >= duty);
    wire       inv_step  = (inverse_line_count == 2'h0) ? frame_evt : (line_end && (inv_cnt_reg == 2'(inverse_line_count - 2'h1)));

    assign state_next = module_enable ? SLCD_ST_RUN : SLCD_ST_IDLE;

    // Set wins over a clearing write in the same cycle
    wire flag_clr = wr_acc && hit_intf && pwdata[`SLCD_INT_FRAME];
    assign flag_next = frame_evt | (flag_reg & ~flag_clr);

    // Display RAM to segment mapping
    wire [1:0]       com_bit = common_order_select ? line_reg : 2'(duty - line_reg);
    logic [NSEG-1:0] seg_bits;
    for (genvar g = 0; g < NSEG; g++) begin : g_seg
        wire [4:0] seg_byte = segment_order_select ? 5'(g) : 5'(NSEG - 1 - g);
        wire [5:0] ram_addr = {area_sel, seg_byte};
        assign seg_bits[g] = ram[ram_addr][com_bit];
    end

    wire [3:0]  line_hot = 4'(4'h1 << line_reg);
    wire [31:0] data_on  = 32'(seg_bits ^ {NSEG{~dsprev}});
    wire [31:0] seg_on   = (display_control == SLCD_DSP_ALLON)  ? 32'(~({33{1'b1}} << NSEG)) :
                           (display_control == SLCD_DSP_ALLOFF) ? 32'h0000_0000 : data_on;
    wire [3:0]  com_on   = (display_control == SLCD_DSP_ALLOFF) ? 4'h1 : line_hot;
    wire        disp_off = (display_control == SLCD_DSP_OFF) || (state_reg == SLCD_ST_IDLE);

    always_comb begin
        pins_next.seg  = seg_on ^ {32{pol_reg}};
        pins_next.com  = com_on ^ {4{pol_reg}};
        pins_next.oe_n = 1'b0;
        if (disp_off) begin
            pins_next.seg  = 32'h0000_0000;
            pins_next.com  = 4'h0;
            pins_next.oe_n = !dis_en;
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (1'b1)
            hit_ram:  rd_mux = {ram[{ram_word, 2'h3}], ram[{ram_word, 2'h2}],
                                ram[{ram_word, 2'h1}], ram[{ram_word, 2'h0}]};
            hit_clk:  rd_mux = {16'h0000, clk_reg};
            hit_ctl:  rd_mux = {16'h0000, ctl_reg};
            hit_tim1: rd_mux = {16'h0000, tim1_reg};
            hit_tim2: rd_mux = {16'h0000, tim2_reg};
            hit_pwr:  rd_mux = {16'h0000, pwr_reg};
            hit_dsp:  rd_mux = {16'h0000, dsp_reg};
            hit_intf: rd_mux = {31'h0, flag_reg};
            hit_inte: rd_mux = {16'h0000, inte_reg};
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    // Display RAM, byte lanes; no reset, contents are software's
    always_ff @(posedge pclk) begin
        for (int b = 0; b < 4; b++) begin
            if (wr_acc && hit_ram && pstrb[b]) begin
                ram[{ram_word, 2'(b)}] <= pwdata[8*b +: 8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_reg  <= `SLCD_CLK_RESET;
            ctl_reg  <= `SLCD_CTL_RESET;
            tim1_reg <= `SLCD_TIM1_RESET;
            tim2_reg <= `SLCD_TIM2_RESET;
            pwr_reg  <= `SLCD_PWR_RESET;
            dsp_reg  <= `SLCD_DSP_RESET;
            inte_reg <= `SLCD_INT_RESET;
            flag_reg <= 1'b0;
        end else begin
            clk_reg  <= clk_next;
            ctl_reg  <= ctl_next;
            tim1_reg <= tim1_next;
            tim2_reg <= tim2_next;
            pwr_reg  <= pwr_next;
            dsp_reg  <= dsp_next;
            inte_reg <= inte_next;
            flag_reg <= flag_next;
        end
    end

    // Read data captured in setup so access completes with no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_reg <= !hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_meta_reg <= 1'b0;
            dbg_sync_reg <= 1'b0;
        end else begin
            dbg_meta_reg <= debug_mode;
            dbg_sync_reg <= dbg_meta_reg;
        end
    end

    // Sequencer counters; all cleared while the module is disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= SLCD_ST_IDLE;
            pre_cnt_reg <= 9'h000;
            ltim_reg    <= 8'h00;
            line_reg    <= 2'h0;
            inv_cnt_reg <= 2'h0;
            pol_reg     <= 1'b0;
        end else begin
            state_reg <= state_next;
            unique case (state_reg)
                SLCD_ST_IDLE: begin
                    pre_cnt_reg <= 9'h000;
                    ltim_reg    <= 8'h00;
                    line_reg    <= 2'h0;
                    inv_cnt_reg <= 2'h0;
                    pol_reg     <= 1'b0;
                end
                SLCD_ST_RUN: begin
                    if (clk_run) begin
                        pre_cnt_reg <= tick ? 9'h000 : 9'(pre_cnt_reg + 9'h001);
                    end
                    if (tick) begin
                        ltim_reg <= line_end ? 8'h00 : 8'(ltim_reg + 8'h01);
                    end
                    if (line_end) begin
                        line_reg    <= frame_evt ? 2'h0 : 2'(line_reg + 2'h1);
                        inv_cnt_reg <= inv_step ? 2'h0 : 2'(inv_cnt_reg + 2'h1);
                    end
                    if (inv_step) begin
                        pol_reg <= !pol_reg;
                    end
                end
            endcase
        end
    end

    // Booster clock from operating-clock ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bst_cnt_reg <= 6'h00;
            bst_reg     <= 1'b0;
        end else if (tick) begin
            if (bst_cnt_reg == 6'(bst_half(tim2_reg[`SLCD_TIM2_BST]) - 6'h01)) begin
                bst_cnt_reg <= 6'h00;
                bst_reg     <= !bst_reg;
            end else begin
                bst_cnt_reg <= 6'(bst_cnt_reg + 6'h01);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_reg <= '{seg: 32'h0000_0000, com: 4'h0, oe_n: 1'b1};
        end else begin
            pins_reg <= pins_next;
        end
    end

    assign prdata       = prdata_reg;
    assign pslverr      = pslverr_reg && psel && penable;
    assign pready       = psel && penable;
    assign lcd_pins     = pins_reg;
    assign frame_irq    = flag_reg && inte_reg[`SLCD_INT_FRAME];
    assign booster_clk  = bst_reg && pwr_reg[`SLCD_PWR_BSTEN];
    assign regulator_en = pwr_reg[`SLCD_PWR_REGULATOR_ENABLE];

    // Checks
    a_clk_write_lock: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_clk && module_enable) |=> $stable(clk_reg)) else $error("clock register changed while enabled");
    a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
        frame_evt |=> flag_reg) else $error("frame flag not set");
    a_flag_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_clr && !frame_evt) |=> !flag_reg) else $error("frame flag not cleared");
    a_flag_zero_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_intf && !pwdata[0] && flag_reg) |=> flag_reg) else $error("zero write cleared flag");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_evt && !(wr_acc && hit_inte)) |=> (frame_irq == inte_reg[`SLCD_INT_FRAME]))
        else $error("irq not gated by enable");
    a_off_discharge: assert property (@(posedge pclk) disable iff (!presetn)
        (disp_off && dis_en) [*2] |-> (!lcd_pins.oe_n && lcd_pins.seg == 32'h0 && lcd_pins.com == 4'h0))
        else $error("pins not discharged");
    a_off_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        (disp_off && !dis_en) [*2] |-> lcd_pins.oe_n) else $error("pins not released");
    a_shutdown_off: assert property (@(posedge pclk) disable iff (!presetn)
        shutdown |=> (display_control == SLCD_DSP_OFF && !regulator_en && !module_enable)) else $error("disable did not turn off");
    a_debug_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (dbg_sync_reg && !clk_reg[`SLCD_CLK_DEBUG_CLOCK_RUN]) |-> !tick) else $error("clock ran in debug");
    a_ram_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_ram && pstrb[0]) |=> ram[{$past(ram_word), 2'h0}] == $past(pwdata[7:0]))
        else $error("RAM byte not stored");
    a_ram_lane_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_ram && !pstrb[0]) |=> ram[{$past(ram_word), 2'h0}] == $past(ram[{ram_word, 2'h0}]))
        else $error("RAM byte changed without strobe");

    c_frame: cover property (@(posedge pclk) disable iff (!presetn) frame_evt);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(frame_irq));
    c_shutdown: cover property (@(posedge pclk) disable iff (!presetn) shutdown);
    c_area1: cover property (@(posedge pclk) disable iff (!presetn) area_sel && display_control == SLCD_DSP_NORMAL && tick);
    c_all_off: cover property (@(posedge pclk) disable iff (!presetn) display_control == SLCD_DSP_ALLOFF && tick);

endmodule

// ### slcd_panel.sv
// Segment LCD panel model: decodes lit segments and the active common line
`timescale 1ns/10ps

module slcd_panel
    import slcd_pkg::*;
(
    input  wire slcd_pins_t pins,   // Pins from the controller
    output logic [31:0]     lit,    // Segments seen on
    output logic [1:0]      line,   // Active common line
    output logic            driven  // Pins out of high impedance
);
    logic       pol;
    logic [3:0] cpos;

    // Inverted frames show as more than one common high
    assign pol    = $countones(pins.com) > 1;
    assign cpos   = pins.com ^ {4{pol}};
    assign line   = cpos[3] ? 2'h3 : cpos[2] ? 2'h2 : cpos[1] ? 2'h1 : 2'h0;
    assign lit    = pins.seg ^ {32{pol}};
    assign driven = !pins.oe_n;
endmodule

// ### segment_lcd_display_controller_test.sv
// Self-checking bench of the segment LCD controller
`timescale 1ns/10ps
`include "slcd_defines.svh"

module segment_lcd_display_controller_test
    import slcd_pkg::*;
;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic        debug_mode = 0;
    logic [3:0]  strb = 4'hf;
    logic [31:0] prdata, rd, d, lit, seed = 32'h044f;
    logic        pready, pslverr, er, frame_irq, booster_clk, regulator_en, driven;
    logic [1:0]  line;
    slcd_pins_t  lcd_pins;
    logic [7:0]  ram [64];
    int          miscompares = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [15:0] ra [8] = '{`SLCD_REG_CLK, `SLCD_REG_CTL, `SLCD_REG_TIM1, `SLCD_REG_TIM2,
                            `SLCD_REG_PWR, `SLCD_REG_DSP, `SLCD_REG_INTF, `SLCD_REG_INTE};
    logic [15:0] rv [8] = '{`SLCD_CLK_RESET, `SLCD_CTL_RESET, `SLCD_TIM1_RESET, `SLCD_TIM2_RESET,
                            `SLCD_PWR_RESET, `SLCD_DSP_RESET, `SLCD_INT_RESET, `SLCD_INT_RESET};
    // Flag register takes no data: a written one only clears
    logic [15:0] wm [8] = '{`SLCD_CLK_WMASK, `SLCD_CTL_WMASK, `SLCD_TIM1_WMASK, `SLCD_TIM2_WMASK,
                            `SLCD_PWR_WMASK, `SLCD_DSP_WMASK, 16'h0000, `SLCD_INT_WMASK};
    logic [10:0] tab [7] = '{{2'h0, 2'h0, 7'h51}, {2'h0, 2'h0, 7'h15}, {2'h1, 2'h0, 7'h41},
                             {2'h3, 2'h2, 7'h71}, {2'h2, 2'h1, 7'h72}, {2'h3, 2'h3, 7'h35},
                             {2'h3, 2'h0, 7'h73}};
    int          per [4] = '{16, 64, 128, 256};

    always #5 pclk = ~pclk;

    slcd_ctrl #(.NSEG(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_mode(debug_mode), .lcd_pins(lcd_pins),
        .frame_irq(frame_irq), .booster_clk(booster_clk), .regulator_en(regulator_en));

    slcd_panel panel (.pins(lcd_pins), .lit(lit), .line(line), .driven(driven));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] exp_lit(input logic [1:0] duty, input logic [1:0] ln, input logic [6:0] dsp);
        logic [31:0] r;
        logic [7:0]  b;
        for (int s = 0; s < 32; s++) begin
            b = ram[(dsp[2] ? 32 : 0) + (dsp[6] ? s : 31 - s)];
            r[s] = b[dsp[5] ? ln : duty - ln] ^ !dsp[4];
        end
        return (dsp[1:0] == 2'h2) ? 32'hffffffff : (dsp[1:0] == 2'h3) ? 32'h0 : r;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(nm, rd, x);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge pclk);
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            results();
        end
    end

    initial begin
        int n, k, t0;
        logic lb;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rdc("reset value", ra[i], {16'h0, rv[i]});
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            // Module kept off, else a frame could set the flag mid-loop
            if (i == 1)
                d[0] = 1'b0;
            apb(1'b1, ra[i], d);
            rdc("masked reg", ra[i], {16'h0, d[15:0] & wm[i] & ~{15'h0, i == 4 && d[15]}});
        end
        rdc("unmapped", 16'h7200, 32'h0);
        check("unmapped err", {31'h0, er}, 32'h1);
        apb(1'b1, `SLCD_REG_CTL, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            d = rnd();
            apb(1'b1, `SLCD_RAM_BASE + 16'(4 * i), d);
            {ram[4*i+3], ram[4*i+2], ram[4*i+1], ram[4*i]} = d;
        end
        for (int i = 0; i < 16; i++)
            rdc("ram", `SLCD_RAM_BASE + 16'(4 * i), {ram[4*i+3], ram[4*i+2], ram[4*i+1], ram[4*i]});
        d = rnd();
        strb <= 4'h2;
        apb(1'b1, `SLCD_RAM_BASE, d);
        strb <= 4'hf;
        ram[1] = d[15:8];
        rdc("ram lane", `SLCD_RAM_BASE, {ram[3], ram[2], ram[1], ram[0]});
        $display("test ram done");
        apb(1'b1, `SLCD_REG_CLK, 32'h0);
        apb(1'b1, `SLCD_REG_TIM1, 32'h0f00);
        apb(1'b1, `SLCD_REG_INTE, 32'h1);
        apb(1'b1, `SLCD_REG_INTF, 32'h1);
        debug_mode <= 1'b1;
        apb(1'b1, `SLCD_REG_CTL, 32'h1);
        apb(1'b1, `SLCD_REG_CLK, 32'h0173);
        rdc("locked clock", `SLCD_REG_CLK, 32'h0);
        idle(1200);
        rdc("debug stop", `SLCD_REG_INTF, 32'h0);
        debug_mode <= 1'b0;
        n = 0;
        while (frame_irq !== 1'b1 && n < 1500) begin
            idle(1);
            n++;
        end
        check("frame irq", {31'h0, frame_irq}, 32'h1);
        rdc("flag set", `SLCD_REG_INTF, 32'h1);
        apb(1'b1, `SLCD_REG_INTE, 32'h0);
        idle(1);
        check("masked irq", {31'h0, frame_irq}, 32'h0);
        apb(1'b1, `SLCD_REG_INTF, 32'h0);
        rdc("flag kept", `SLCD_REG_INTF, 32'h1);
        apb(1'b1, `SLCD_REG_INTF, 32'h1);
        rdc("flag clear", `SLCD_REG_INTF, 32'h0);
        $display("test interrupt done");
        apb(1'b1, `SLCD_REG_CTL, 32'h0);
        apb(1'b1, `SLCD_REG_CLK, 32'h0100);
        apb(1'b1, `SLCD_REG_CTL, 32'h1);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, `SLCD_REG_TIM1, {30'h0, tab[i][10:9]});
            apb(1'b1, `SLCD_REG_DSP, {25'h0, tab[i][6:0]});
            idle(2);
            n = 0;
            while ((line !== tab[i][8:7] || driven !== 1'b1) && n < 400) begin
                idle(1);
                n++;
            end
            check("lit", lit, exp_lit(tab[i][10:9], tab[i][8:7], tab[i][6:0]));
        end
        apb(1'b1, `SLCD_REG_DSP, 32'h0050);
        apb(1'b1, `SLCD_REG_CTL, 32'h3);
        idle(2);
        check("off driven", {31'h0, lcd_pins.oe_n}, 32'h0);
        check("off low", lcd_pins.seg, 32'h0);
        apb(1'b1, `SLCD_REG_CTL, 32'h1);
        idle(2);
        check("off hi z", {31'h0, lcd_pins.oe_n}, 32'h1);
        $display("test display done");
        apb(1'b1, `SLCD_REG_PWR, 32'h0010);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `SLCD_REG_TIM2, {22'h0, 2'(c), 8'h0});
            k = 0;
            n = 0;
            t0 = 0;
            lb = booster_clk;
            while (k < 3 && n < 1200) begin
                idle(1);
                n++;
                if (booster_clk === 1'b1 && lb === 1'b0) begin
                    k++;
                    if (k == 2)
                        t0 = n;
                end
                lb = booster_clk;
            end
            check("booster period", 32'(n - t0), 32'(per[c]));
        end
        $display("test booster done");
        apb(1'b1, `SLCD_REG_PWR, 32'h0011);
        apb(1'b1, `SLCD_REG_DSP, 32'h0051);
        idle(1);
        check("regulator on", {31'h0, regulator_en}, 32'h1);
        apb(1'b1, `SLCD_REG_CTL, 32'h0);
        rdc("forced off", `SLCD_REG_DSP, 32'h0050);
        rdc("regulator bit", `SLCD_REG_PWR, 32'h0010);
        check("regulator off", {31'h0, regulator_en}, 32'h0);
        $display("test shutdown done");
        results();
    end
endmodule
